// ### src/mfd_pkg.sv
// constants, field layouts and carrier types of the modem format and deviation bank
// Functional notes
// - adc clock is crystal over twice (code+1)
// - scrambler enable scrambles tx and rx bits
// - format 00 is nrz, 01 manchester
// - formats 10/11 transparent, clock pin 0/1
// - shaping enable applies gaussian shaping, resets one
// - exponent in bits six to four, reset six
// - mantissa in low four bits, reset eight
// - low band deviation: fref*m*2^(x-16)
// - high band deviation: fref*m*2^(x-15)
// - zero mantissa selects on-off keying
// - reference frequency is crystal over (code+1)
package mfd_pkg;
  // register offsets
  localparam logic [7:0] MODEM_CONFIG_ADDR = 8'h0d;
  localparam logic [7:0] FREQ_DEVIATION_ADDR = 8'h0e;
  localparam logic [7:0] REF_CONFIG_ADDR = 8'h20;
  // reset values
  localparam logic [7:0] MODEM_CONFIG_RESET = 8'h30;
  localparam logic [7:0] FREQ_DEVIATION_RESET = 8'he8;
  localparam logic [7:0] REF_CONFIG_RESET = 8'h02;
  // field positions
  localparam int ADC_DIV_LSB = 4;
  localparam int SCRAMBLER_ENABLE_BIT = 2;
  localparam int FORMAT_LSB = 0;
  localparam int SHAPING_BIT = 7;
  localparam int TX_DEV_EXP_LSB = 4;
  localparam int TX_DEV_MANT_LSB = 0;
  localparam int REF_DIV_LSB = 0;
  localparam int BAND_HIGH_BIT = 3;
  // deviation word counts in units of fref / 2^16; high band adds one to the exponent
  localparam int DEV_WORD_WIDTH = 12;
  // bit timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int FIFO_DEPTH = 4;
  // pn9 seed
  localparam logic [8:0] PN9_SEED = 9'h1ff;

  typedef enum logic [1:0] {
    FMT_NRZ = 2'h0,
    FMT_MANCHESTER = 2'h1,
    FMT_UART_LOW = 2'h2,
    FMT_UART_HIGH = 2'h3
  } mfd_format_type;

  typedef struct packed {
    logic [2:0] adcDiv;
    logic scramblerEnable;
    mfd_format_type format;
  } mfd_modem_cfg_type;

  typedef struct packed {
    logic shapingEnable;
    logic [2:0] txDeviationExponent;
    logic [3:0] txDeviationMantissa;
  } mfd_deviation_cfg_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } mfd_reg_req_type;
endpackage

// ### src/mfd_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module mfd_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  // honest full and empty from the fill count
  assign inReady = (count_q < (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];

  // pointers and count
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (push) mem_q[wrPtr_q] <= inData;
  end

  a_fifo_full: assert property (@(posedge clk) disable iff (rst)
    count_q == (PW+1)'(DEPTH) |-> !inReady) else $error("fifo accepts while full");
endmodule

// ### src/mfd_pn9.sv
// nine-stage pseudo-random scrambler, x^9 + x^5 + 1
`timescale 1ns/1ps
module mfd_pn9 (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic step,
  input wire logic inBit,
  output logic outBit
);
  logic [8:0] lfsr_q;
  wire feedback = lfsr_q[8] ^ lfsr_q[4];

  // the sequence restarts whenever scrambling is off, so both ends stay aligned
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      lfsr_q <= mfd_pkg::PN9_SEED;
    end else if (step) begin
      lfsr_q <= {lfsr_q[7:0], feedback};
    end
  end

  assign outBit = enable ? (inBit ^ lfsr_q[8]) : inBit;
endmodule

// ### src/mfd_top.sv
// modem format and deviation register bank with its bit path
`timescale 1ns/1ps
module mfd_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic txBit,
  input wire logic txValid,
  output logic txReady,
  output logic modemTxBit,
  output logic [1:0] modemTxLevel,
  output logic dataClockPin,
  input wire logic rxBit,
  input wire logic rxValid,
  output logic rxDataBit,
  output logic rxDataValid,
  output logic adcClock,
  output logic refTick,
  output logic [mfd_pkg::DEV_WORD_WIDTH-1:0] deviationWord,
  output logic ookMode,
  output logic shapingEnable
);
  import mfd_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_SECOND = 3'b100
  } mfd_tx_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // register bank

  mfd_modem_cfg_type modemCfg_q;
  mfd_deviation_cfg_type devCfg_q;
  logic [2:0] refDiv_q;
  logic bandHigh_q;
  logic [7:0] regRdData_q;
  logic [7:0] regRdData_d;
  mfd_reg_req_type req;

  // bus request bundle and address decode
  assign req = '{addr: regAddr, wrData: regWrData, wr: regWr, rd: regRd};
  wire selModem = (req.addr == MODEM_CONFIG_ADDR);
  wire selDev = (req.addr == FREQ_DEVIATION_ADDR);
  wire selRef = (req.addr == REF_CONFIG_ADDR);
  wire [7:0] modemRead = {1'b0, modemCfg_q.adcDiv, 1'b0, modemCfg_q.scramblerEnable,
                          modemCfg_q.format};
  wire [7:0] devRead = devCfg_q;
  wire [7:0] refRead = {4'h0, bandHigh_q, refDiv_q};

  // read mux; unmapped addresses read zero, data stand only after a read strobe
  always_comb begin
    regRdData_d = 8'h00;
    if (req.rd) begin
      if (selModem) regRdData_d = modemRead;
      else if (selDev) regRdData_d = devRead;
      else if (selRef) regRdData_d = refRead;
    end
  end

  // configuration writes; reserved modem bits are not stored and read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      modemCfg_q <= mfd_modem_cfg_type'({MODEM_CONFIG_RESET[6:4], MODEM_CONFIG_RESET[2:0]});
      devCfg_q <= mfd_deviation_cfg_type'(FREQ_DEVIATION_RESET);
      refDiv_q <= REF_CONFIG_RESET[2:0];
      bandHigh_q <= REF_CONFIG_RESET[BAND_HIGH_BIT];
    end else if (req.wr) begin
      if (selModem) begin
        modemCfg_q.adcDiv <= req.wrData[ADC_DIV_LSB +: 3];
        modemCfg_q.scramblerEnable <= req.wrData[SCRAMBLER_ENABLE_BIT];
        modemCfg_q.format <= mfd_format_type'(req.wrData[FORMAT_LSB +: 2]);
      end
      if (selDev) begin
        devCfg_q.shapingEnable <= req.wrData[SHAPING_BIT];
        devCfg_q.txDeviationExponent <= req.wrData[TX_DEV_EXP_LSB +: 3];
        devCfg_q.txDeviationMantissa <= req.wrData[TX_DEV_MANT_LSB +: 4];
      end
      if (selRef) begin
        refDiv_q <= req.wrData[REF_DIV_LSB +: 3];
        bandHigh_q <= req.wrData[BAND_HIGH_BIT];
      end
    end
  end

  // read data register
  always_ff @(posedge clk) begin
    if (rst) regRdData_q <= 8'h00;
    else regRdData_q <= regRdData_d;
  end
  assign regRdData = regRdData_q;

  ////////////////////////////////////////////////////////////////////////////
  // adc and reference clock dividers

  logic [2:0] adcCnt_q;
  logic adcClock_q;
  logic [2:0] refCnt_q;
  logic refTick_q;
  wire adcRun = (modemCfg_q.adcDiv != 3'h0);
  wire adcWrap = (adcCnt_q >= modemCfg_q.adcDiv);
  wire refRun = (refDiv_q != 3'h0);
  wire refWrap = (refCnt_q >= refDiv_q);

  // adc clock toggles every code+1 crystal cycles, a period of 2*(code+1); code 0 stops it
  always_ff @(posedge clk) begin
    if (rst || !adcRun) begin
      adcCnt_q <= 3'h0;
      adcClock_q <= 1'b0;
    end else if (adcWrap) begin
      adcCnt_q <= 3'h0;
      adcClock_q <= !adcClock_q;
    end else begin
      adcCnt_q <= adcCnt_q + 3'h1;
    end
  end
  assign adcClock = adcClock_q;

  // reference tick once every code+1 crystal cycles; code 0 stops it
  always_ff @(posedge clk) begin
    if (rst || !refRun) begin
      refCnt_q <= 3'h0;
      refTick_q <= 1'b0;
    end else begin
      refCnt_q <= refWrap ? 3'h0 : refCnt_q + 3'h1;
      refTick_q <= refWrap;
    end
  end
  assign refTick = refTick_q;

  ////////////////////////////////////////////////////////////////////////////
  // deviation word and keying

  logic [DEV_WORD_WIDTH-1:0] deviationWord_q;
  logic ookMode_q;
  logic shaping_q;
  // low band: m << x in fref/2^16 units; high band doubles it (exponent minus 15)
  wire [3:0] devShift = {1'b0, devCfg_q.txDeviationExponent} + {3'h0, bandHigh_q};
  wire [DEV_WORD_WIDTH-1:0] devWord =
    DEV_WORD_WIDTH'({8'h00, devCfg_q.txDeviationMantissa} << devShift);

  always_ff @(posedge clk) begin
    if (rst) begin
      deviationWord_q <= '0;
      ookMode_q <= 1'b0;
      shaping_q <= 1'b1;
    end else begin
      deviationWord_q <= devWord;
      ookMode_q <= (devCfg_q.txDeviationMantissa == 4'h0);
      shaping_q <= devCfg_q.shapingEnable;
    end
  end
  assign deviationWord = deviationWord_q;
  assign ookMode = ookMode_q;
  assign shapingEnable = shaping_q;

  ////////////////////////////////////////////////////////////////////////////
  // transmit path: fifo, scrambler, line coder

  logic fifoBit;
  logic fifoValid;
  logic scrBit;
  logic [$clog2(BIT_CYCLES)-1:0] bitCnt_q;
  mfd_tx_state_type txState_q;
  mfd_tx_state_type txState_d;
  logic curBit_q;
  logic modemTxBit_q;
  logic prevBit_q;
  logic [1:0] txLevel_q;
  logic dataClock_q;

  wire isUart = modemCfg_q.format[1];
  wire isManchester = (modemCfg_q.format == FMT_MANCHESTER);
  wire halfDone = (bitCnt_q == ($clog2(BIT_CYCLES))'(HALF_BIT_CYCLES - 1));
  wire bitDone = (bitCnt_q == ($clog2(BIT_CYCLES))'(BIT_CYCLES - 1));
  // transparent modes pass bits as soon as they arrive; coded modes take one per bit time
  wire takeBit = isUart ? 1'b1 : (txState_q == ST_IDLE || bitDone);
  wire popBit = takeBit && fifoValid;

  mfd_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) txFifo (
    .clk(clk),
    .rst(rst),
    .inData(txBit),
    .inValid(txValid),
    .inReady(txReady),
    .outData(fifoBit),
    .outValid(fifoValid),
    .outReady(takeBit)
  );

  mfd_pn9 txScrambler (
    .clk(clk),
    .rst(rst),
    .enable(modemCfg_q.scramblerEnable),
    .step(popBit),
    .inBit(fifoBit),
    .outBit(scrBit)
  );

  // bit framing: a new bit starts in st_first, manchester sends its inverse in st_second
  always_comb begin
    txState_d = txState_q;
    case (txState_q)
      ST_IDLE: begin
        if (popBit && !isUart) txState_d = ST_FIRST;
      end
      ST_FIRST: begin
        if (isUart) txState_d = ST_IDLE;
        else if (halfDone) txState_d = ST_SECOND;
      end
      ST_SECOND: begin
        if (isUart) txState_d = ST_IDLE;
        else if (bitDone) txState_d = popBit ? ST_FIRST : ST_IDLE;
      end
      default: txState_d = ST_IDLE;
    endcase
  end

  // state and bit timer
  always_ff @(posedge clk) begin
    if (rst) begin
      txState_q <= ST_IDLE;
      bitCnt_q <= '0;
      curBit_q <= 1'b0;
    end else begin
      txState_q <= txState_d;
      bitCnt_q <= (txState_d == ST_IDLE || popBit) ? '0 : bitCnt_q + 1'b1;
      if (popBit) curBit_q <= scrBit;
    end
  end

  // line coding of the outgoing bit
  wire nrzOut = popBit ? scrBit : curBit_q;
  wire manchOut = (txState_d == ST_SECOND) ? !curBit_q : nrzOut;
  wire codedBit = isUart ? (popBit ? scrBit : modemTxBit_q) :
                  isManchester ? manchOut : nrzOut;
  // gaussian shaping modelled as a two-tap average onto a three-level symbol
  wire [1:0] shapedLevel = shaping_q ? ({1'b0, codedBit} + {1'b0, prevBit_q}) :
                           {codedBit, 1'b0};
  // data clock: fixed in transparent modes, otherwise high in the first half of a bit
  wire dataClockNext = isUart ? modemCfg_q.format[0] : (txState_d == ST_FIRST);

  always_ff @(posedge clk) begin
    if (rst) begin
      modemTxBit_q <= 1'b0;
      prevBit_q <= 1'b0;
      txLevel_q <= 2'h0;
      dataClock_q <= 1'b0;
    end else begin
      modemTxBit_q <= codedBit;
      prevBit_q <= codedBit;
      txLevel_q <= shapedLevel;
      dataClock_q <= dataClockNext;
    end
  end
  assign modemTxBit = modemTxBit_q;
  assign modemTxLevel = txLevel_q;
  assign dataClockPin = dataClock_q;

  ////////////////////////////////////////////////////////////////////////////
  // receive path: descrambler

  logic rxPlain;
  logic rxDataBit_q;
  logic rxDataValid_q;

  mfd_pn9 rxScrambler (
    .clk(clk),
    .rst(rst),
    .enable(modemCfg_q.scramblerEnable),
    .step(rxValid),
    .inBit(rxBit),
    .outBit(rxPlain)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      rxDataBit_q <= 1'b0;
      rxDataValid_q <= 1'b0;
    end else begin
      rxDataBit_q <= rxValid ? rxPlain : rxDataBit_q;
      rxDataValid_q <= rxValid;
    end
  end
  assign rxDataBit = rxDataBit_q;
  assign rxDataValid = rxDataValid_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_dev_write;
    regWr && selDev;
  endsequence

  sequence s_dev_read;
    regRd && selDev && !regWr;
  endsequence

  a_dev_readback: assert property (@(posedge clk) disable iff (rst)
    s_dev_write ##1 s_dev_read |=> regRdData == $past(regWrData, 2))
    else $error("deviation register readback differs from write");

  a_read_idle: assert property (@(posedge clk) disable iff (rst)
    !$past(regRd) |-> regRdData == 8'h00) else $error("read data outside read slot");

  a_reset_values: assert property (@(posedge clk)
    $past(rst) |-> devCfg_q == FREQ_DEVIATION_RESET && modemRead == MODEM_CONFIG_RESET)
    else $error("register reset value wrong");

  a_uart_clock: assert property (@(posedge clk) disable iff (rst)
    isUart [*2] |-> dataClockPin == $past(modemCfg_q.format[0]))
    else $error("data clock pin not held in transparent mode");

  a_ook_select: assert property (@(posedge clk) disable iff (rst)
    ookMode == ($past(devCfg_q.txDeviationMantissa) == 4'h0))
    else $error("on-off keying does not follow zero mantissa");

  a_dev_band: assert property (@(posedge clk) disable iff (rst)
    $stable(devCfg_q) && bandHigh_q && $past(bandHigh_q) && devCfg_q.txDeviationExponent < 3'h7
    |-> deviationWord == DEV_WORD_WIDTH'({7'h00, devCfg_q.txDeviationMantissa, 1'b0}
        << devCfg_q.txDeviationExponent))
    else $error("high band deviation word wrong");

  a_adc_stopped: assert property (@(posedge clk) disable iff (rst)
    $rose(adcClock) |-> $past(modemCfg_q.adcDiv) != 3'h0)
    else $error("adc clock runs on code zero");

  a_rx_clear: assert property (@(posedge clk) disable iff (rst)
    rxValid && !modemCfg_q.scramblerEnable |=> rxDataValid && rxDataBit == $past(rxBit))
    else $error("receive bit altered with scrambling off");

  a_manch_half: assert property (@(posedge clk) disable iff (rst)
    txState_q == ST_SECOND && $past(isManchester) |-> modemTxBit == !curBit_q)
    else $error("manchester second half not inverted");

  a_ref_stopped: assert property (@(posedge clk) disable iff (rst)
    refTick |-> $past(refDiv_q) != 3'h0)
    else $error("reference tick runs on code zero");
endmodule

// ### sim/mfd_host_model.sv
// host side model: feeds transmit bits to the bank and received bits from the air
`timescale 1ns/1ps
module mfd_host_model (
  input wire logic clk,
  output logic txBit,
  output logic txValid,
  input wire logic txReady,
  output logic rxBit,
  output logic rxValid
);
  bit sentQ[$];
  int stallSeen = 0;
  bit timedOut = 0;
  // idle levels at time zero
  initial begin
    txBit = 1'b0;
    txValid = 1'b0;
    rxBit = 1'b1;
    rxValid = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // offer n random bits back to back, each held until taken
  task automatic send(input int n);
    int t;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      txBit <= 1'($urandom);
      txValid <= 1'b1;
      t = 0;
      do begin
        @(posedge clk);
        t++;
        if (!txReady) stallSeen++;
      end while (!txReady && t < 500);
      if (!txReady) timedOut = 1;
      sentQ.push_back(txBit);
    end
    txValid <= 1'b0;
  endtask
  // received zeros, one per pulse; the line shows the inverse between bits
  task automatic recv(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxBit <= 1'b0;
      rxValid <= 1'b1;
      @(posedge clk);
      rxBit <= 1'b1;
      rxValid <= 1'b0;
    end
  endtask
endmodule

// ### sim/modem_format_deviation_config_test.sv
// self-checking bench of the modem format and deviation bank
`timescale 1ns/1ps
module modem_format_deviation_config_test;
  import mfd_pkg::*;
  logic clk, rst, regWr, regRd, txBit, txValid, txReady, rxBit, rxValid;
  logic [7:0] regAddr, regWrData, regRdData;
  logic modemTxBit, dataClockPin, rxDataBit, rxDataValid, adcClock, refTick;
  logic ookMode, shapingEnable, rxvPrev;
  logic [1:0] modemTxLevel;
  logic [DEV_WORD_WIDTH-1:0] deviationWord;
  int n_fail = 0;
  int checks_done = 0;
  int ones, nA, nR, m, x, b, s, onesBase;
  logic lastA;
  mfd_top DUT (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txBit(txBit),
    .txValid(txValid), .txReady(txReady), .modemTxBit(modemTxBit),
    .modemTxLevel(modemTxLevel), .dataClockPin(dataClockPin), .rxBit(rxBit),
    .rxValid(rxValid), .rxDataBit(rxDataBit), .rxDataValid(rxDataValid),
    .adcClock(adcClock), .refTick(refTick), .deviationWord(deviationWord),
    .ookMode(ookMode), .shapingEnable(shapingEnable));
  mfd_host_model host (.clk(clk), .txBit(txBit), .txValid(txValid),
    .txReady(txReady), .rxBit(rxBit), .rxValid(rxValid));
  ////////////////////////////////////////////////////////////////
  // clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(12'(regRdData), 12'(exp));
  endtask
  // write then read back in the very next cycle, no gap
  task automatic wrRd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(12'(regRdData), 12'(exp));
  endtask
  // bounded wait for the next rising data clock
  task automatic waitRise();
    int t;
    t = 0;
    while (dataClockPin !== 1'b0 && t < 100) begin
      @(posedge clk);
      #1;
      t++;
    end
    while (dataClockPin !== 1'b1 && t < 200) begin
      @(posedge clk);
      #1;
      t++;
    end
    if (dataClockPin !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // coded line: nrz holds the bit, manchester inverts it in the second half
  task automatic codedCheck(input int f);
    for (int i = 0; i < 6; i++) begin
      waitRise();
      repeat (10) @(posedge clk);
      #1;
      chk(12'(modemTxBit), 12'(host.sentQ[i]));
      chk(12'(modemTxLevel), host.sentQ[i] ? 12'h2 : 12'h0);
      if (f == 1) begin
        repeat (20) @(posedge clk);
        #1;
        chk(12'(modemTxBit), 12'(!host.sentQ[i]));
        chk(12'(modemTxLevel), host.sentQ[i] ? 12'h0 : 12'h2);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // receive monitor: result one cycle after each received bit
  always @(posedge clk) begin
    if (!rst) chk(12'(rxDataValid), 12'(rxvPrev));
    if (rxDataValid) ones += rxDataBit;
    rxvPrev = rxValid;
  end
  // main sequence
  initial begin
    void'($urandom(3));
    rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0d, 8'h30);
    rd(8'h0e, 8'he8);
    rd(8'h20, REF_CONFIG_RESET);
    rd(8'h55, 8'h00);
    chk(12'(shapingEnable), 12'h1);
    chk(deviationWord, 12'h200);
    wr(8'h0d, 8'h77);
    rd(8'h0d, 8'h77);
    for (int c = 0; c < 8; c++) begin
      wr(MODEM_CONFIG_ADDR, 8'(c << 4));
      wr(REF_CONFIG_ADDR, 8'(c));
      repeat (40) @(posedge clk);
      #1;
      nA = 0;
      nR = 0;
      lastA = adcClock;
      repeat (16 * (c + 1)) begin
        @(posedge clk);
        #1;
        if (adcClock && !lastA) nA++;
        nR += refTick;
        lastA = adcClock;
      end
      chk(12'(nA), c ? 12'h8 : 12'h0);
      chk(12'(nR), c ? 12'h10 : 12'h0);
    end
    for (int i = 0; i < 8; i++) begin
      m = i ? $urandom_range(15, 8) : 0;
      x = $urandom_range(7, 0);
      b = $urandom_range(1, 0);
      s = $urandom_range(1, 0);
      wrRd(FREQ_DEVIATION_ADDR, {s[0], x[2:0], m[3:0]}, {s[0], x[2:0], m[3:0]});
      wr(REF_CONFIG_ADDR, {4'h0, b[0], 3'h2});
      repeat (3) @(posedge clk);
      #1;
      chk(deviationWord, 12'(m << (x + b)));
      chk(12'(ookMode), 12'(m == 0));
      chk(12'(shapingEnable), 12'(s));
      rd(8'h0e, {s[0], x[2:0], m[3:0]});
    end
    for (int f = 0; f < 4; f++) begin
      wr(MODEM_CONFIG_ADDR, 8'h70 | 8'(f));
      if (f > 1) begin
        host.sentQ.delete();
        host.send(1);
        repeat (2) @(posedge clk);
        #1;
        chk(12'(modemTxBit), 12'(host.sentQ[0]));
        repeat (4) @(posedge clk);
        repeat (3) begin
          repeat (7) @(posedge clk);
          #1;
          chk(12'(dataClockPin), 12'(f & 1));
        end
      end else begin
        host.sentQ.delete();
        fork
          host.send(6);
          codedCheck(f);
        join
      end
    end
    chk(12'(host.timedOut), 12'h0);
    chk(12'(host.stallSeen > 0), 12'h1);
    chk(12'(txReady), 12'h1);
    for (int e = 0; e < 2; e++) begin
      wr(MODEM_CONFIG_ADDR, 8'h70 | 8'(e << 2));
      onesBase = ones;
      host.recv(511);
      repeat (2) @(posedge clk);
      chk(12'(ones - onesBase), e ? 12'(256) : 12'h0);
    end
    report_and_stop();
  end
endmodule
